// >>> design/spmsb_baud_gen.v
// Baud divider producing oversample and bit-rate enable pulses from the divisor.
`timescale 1ns/1ps
`include "spmsb_defs.vh"
module spmsb_baud_gen #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             reset_n,
  // Divisor, 1 to 65535
  input  wire [WIDTH-1:0] divisor,
  // Enables
  output reg              sampleTick,
  output reg              bitTick
);
  reg [WIDTH-1:0] divCount_reg;
  reg [3:0]       overCount_reg;

  // Divide clock by divisor
  // A zero divisor is treated as one so the divider never stalls.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount_reg  <= {WIDTH{1'b0}};
      overCount_reg <= 4'h0;
      sampleTick    <= 1'b0;
      bitTick       <= 1'b0;
    end else begin
      sampleTick <= 1'b0;
      bitTick    <= 1'b0;
      if (divCount_reg + {{(WIDTH-1){1'b0}}, 1'b1} >= divisor) begin
        divCount_reg <= {WIDTH{1'b0}};
        sampleTick   <= 1'b1;
        overCount_reg <= overCount_reg + 4'h1;
        if (overCount_reg == 4'hF) begin
          bitTick <= 1'b1;
        end
      end else begin
        divCount_reg <= divCount_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // spmsb_baud_gen

// >>> design/spmsb_serial_port.v
// Per-port modem status, scratch, divisor latch and RS-485 direction logic.
// Behaviour
// - Set clear-to-send change flag at status bit 0 on any level change.
// - Set data-set-ready change flag at status bit 1 on any level change.
// - Set ring flag at bit 2 only on ring pin low-to-high.
// - Set carrier-detect change flag at status bit 3 on any level change.
// - Status bits 4 to 7 show inverted pins: CTS, DSR, ring, carrier.
// - Reading the status register clears the four change flags.
// - In RS-232 mode scratch register stores data only, no side effects.
// - Scratch bits 6 and 7 select RS-485 mode and direction polarity.
// - Any divisor from 1 to 65535 divides the input clock.
// - Bit rate equals input clock over sixteen times divisor.
// - Divisor is 256 times high byte plus low byte.
// - Divisor bytes at offsets 0,1, resets 0x01/0x00, reachable with latch enable.
// - Bit 7 clear disables RS-485; bit 6 chooses direction output polarity.
// - In RS-485 the direction output selects transmit while sending.
// - RS-422 runs full duplex with no direction control.
// - Four ports use bulk endpoints 1 to 8; endpoint 9 status.
// - Latch enable bit routes offsets 0 and 1 to divisor bytes.
`timescale 1ns/1ps
`include "spmsb_defs.vh"
module spmsb_serial_port #(
  parameter PORT_NUM = 1
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  // Register access, one byte per request
  input  wire [2:0] regAddr,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  output reg        regRdValid,
  // Transmit activity from the serial engine
  input  wire       txBusy,
  // Active-low modem pins
  input  wire       ctsPin_n,
  input  wire       dsrPin_n,
  input  wire       riPin_n,
  input  wire       dcdPin_n,
  // Direction output and line format
  output reg        dtrPin,
  output reg        lineFormatLatch,
  // Baud enables
  output reg        sampleTick,
  output reg        bitTick,
  // Endpoint map
  input  wire       highSpeed,
  input  wire       statusLong,
  output reg  [3:0] bulkInEp,
  output reg  [3:0] bulkOutEp,
  output reg  [9:0] bulkPacketBytes,
  output reg  [3:0] statusEp,
  output reg  [3:0] statusPacketBytes
);
  reg [7:0]  divLow_reg;
  reg [7:0]  divHigh_reg;
  reg [7:0]  lineFormat_reg;
  reg [7:0]  scratch_reg;
  reg [3:0]  delta_reg;
  reg [3:0]  delta_next;
  reg [3:0]  pinMeta_reg;
  reg [3:0]  pinSync_reg;
  reg [3:0]  pinPrev_reg;
  wire [15:0] divisor;
  wire        latchEn;
  wire        sampleTickW;
  wire        bitTickW;
  wire        rs485En;
  wire        rs485Pol;

  assign latchEn = lineFormat_reg[`SPMSB_BIT_LATCH_EN];
  assign divisor = {divHigh_reg, divLow_reg};
  assign rs485En  = scratch_reg[`SPMSB_BIT_485_EN];
  assign rs485Pol = scratch_reg[`SPMSB_BIT_485_POL];

  // Pins come from outside the clock domain, so two flops first.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_reg <= 4'hF;
      pinSync_reg <= 4'hF;
      pinPrev_reg <= 4'hF;
    end else begin
      pinMeta_reg <= {dcdPin_n, riPin_n, dsrPin_n, ctsPin_n};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // Change flags; a new change wins over the read clear.
  always @* begin
    delta_next = delta_reg;
    if (regRead && regAddr == `SPMSB_OFF_STATUS_IN) begin
      delta_next = 4'h0;
    end
    if (pinSync_reg[0] != pinPrev_reg[0]) begin
      delta_next[0] = 1'b1;
    end
    if (pinSync_reg[1] != pinPrev_reg[1]) begin
      delta_next[1] = 1'b1;
    end
    if (pinSync_reg[2] && !pinPrev_reg[2]) begin
      delta_next[2] = 1'b1;
    end
    if (pinSync_reg[3] != pinPrev_reg[3]) begin
      delta_next[3] = 1'b1;
    end
  end

  // Register writes; offsets 0 and 1 only hit the divisor with latch enable.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divLow_reg     <= `SPMSB_RST_DIV_LOW;
      divHigh_reg    <= `SPMSB_RST_DIV_HIGH;
      lineFormat_reg <= `SPMSB_RST_LINE_FORMAT;
      scratch_reg    <= `SPMSB_RST_SCRATCH;
      delta_reg      <= 4'h0;
    end else begin
      delta_reg <= delta_next;
      if (regWrite) begin
        case (regAddr)
          `SPMSB_OFF_DIV_LOW: begin
            if (latchEn) begin
              divLow_reg <= regWrData;
            end
          end
          `SPMSB_OFF_DIV_HIGH: begin
            if (latchEn) begin
              divHigh_reg <= regWrData;
            end
          end
          `SPMSB_OFF_LINE_FORMAT: begin
            lineFormat_reg <= regWrData;
          end
          `SPMSB_OFF_SCRATCH: begin
            scratch_reg <= regWrData;
          end
          default: begin
            lineFormat_reg <= lineFormat_reg;
          end
        endcase
      end
    end
  end

  // Read data; blocked divisor and unhandled offsets read zero.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData  <= `SPMSB_RST_STATUS_IN;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        case (regAddr)
          `SPMSB_OFF_DIV_LOW: begin
            regRdData <= latchEn ? divLow_reg : 8'h00;
          end
          `SPMSB_OFF_DIV_HIGH: begin
            regRdData <= latchEn ? divHigh_reg : 8'h00;
          end
          `SPMSB_OFF_LINE_FORMAT: begin
            regRdData <= lineFormat_reg;
          end
          `SPMSB_OFF_STATUS_IN: begin
            regRdData <= {~pinSync_reg, delta_reg};
          end
          `SPMSB_OFF_SCRATCH: begin
            regRdData <= scratch_reg;
          end
          default: begin
            regRdData <= 8'h00;
          end
        endcase
      end
    end
  end

  // Direction output; in RS-232 and RS-422 modes it stays low.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dtrPin          <= 1'b0;
      lineFormatLatch <= 1'b0;
    end else begin
      lineFormatLatch <= latchEn;
      if (rs485En) begin
        dtrPin <= rs485Pol ? txBusy : ~txBusy;
      end else begin
        dtrPin <= 1'b0;
      end
    end
  end

  spmsb_baud_gen #(
    .WIDTH(16)
  ) uBaud (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .divisor    (divisor),
    .sampleTick (sampleTickW),
    .bitTick    (bitTickW)
  );

  // Ticks are registered once more so outputs come from flops.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleTick <= 1'b0;
      bitTick    <= 1'b0;
    end else begin
      sampleTick <= sampleTickW;
      bitTick    <= bitTickW;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bulkInEp          <= 4'h0;
      bulkOutEp         <= 4'h0;
      bulkPacketBytes   <= `SPMSB_EP_FS_BYTES;
      statusEp          <= `SPMSB_EP_STATUS;
      statusPacketBytes <= `SPMSB_EP_STAT_SHORT;
    end else begin
      bulkInEp          <= PORT_NUM[2:0] * 4'h2 - 4'h1;
      bulkOutEp         <= PORT_NUM[2:0] * 4'h2;
      bulkPacketBytes   <= highSpeed ? `SPMSB_EP_HS_BYTES : `SPMSB_EP_FS_BYTES;
      statusEp          <= `SPMSB_EP_STATUS;
      statusPacketBytes <= statusLong ? `SPMSB_EP_STAT_LONG : `SPMSB_EP_STAT_SHORT;
    end
  end
endmodule // spmsb_serial_port

// >>> include/spmsb_defs.vh
// Register offsets, field positions, reset values and endpoint constants of the serial port block.
`ifndef SPMSB_DEFS_VH
`define SPMSB_DEFS_VH
`define SPMSB_OFF_DIV_LOW      3'h0
`define SPMSB_OFF_DIV_HIGH     3'h1
`define SPMSB_OFF_LINE_FORMAT  3'h3
`define SPMSB_OFF_STATUS_IN    3'h6
`define SPMSB_OFF_SCRATCH      3'h7
`define SPMSB_RST_DIV_LOW      8'h01
`define SPMSB_RST_DIV_HIGH     8'h00
`define SPMSB_RST_LINE_FORMAT  8'h00
`define SPMSB_RST_STATUS_IN    8'h00
`define SPMSB_RST_SCRATCH      8'h00
`define SPMSB_BIT_LATCH_EN     7
`define SPMSB_BIT_485_EN       7
`define SPMSB_BIT_485_POL      6
`define SPMSB_OVERSAMPLE       5'h10
`define SPMSB_DIV_MULT         9'h100
`define SPMSB_EP_PORTS         4
`define SPMSB_EP_STATUS        4'h9
`define SPMSB_EP_FS_BYTES      10'h040
`define SPMSB_EP_HS_BYTES      10'h200
`define SPMSB_EP_STAT_SHORT    4'h5
`define SPMSB_EP_STAT_LONG     4'hD
`endif

// >>> verif/spmsb_modem_model.sv
// Modem-side model that drives the active-low status pins.
`timescale 1ns/1ps
module spmsb_modem_model (
  // Clock
  input  wire       ref_clk,
  // Requested levels, a set bit asserts the line
  input  wire [3:0] assertReq,
  // Pins {carrier, ring, data-set-ready, clear-to-send}
  output reg  [3:0] pinsN
);
  // Pins move just after an edge, so the port never sees them at a sampling instant.
  initial pinsN = 4'hF;
  always @(posedge ref_clk) begin
    pinsN <= #1 ~assertReq;
  end
endmodule // spmsb_modem_model

// >>> verif/spmsb_port_sva.sv
// Port-level assertions for the serial port block.
`timescale 1ns/1ps
module spmsb_port_sva #(parameter PORT_NUM = 1) (
  // Clock, reset and registers
  input wire       ref_clk,
  input wire       reset_n,
  input wire [2:0] regAddr,
  input wire       regWrite,
  input wire       regRead,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  // Line side
  input wire       txBusy,
  input wire       ctsPin_n,
  input wire       dsrPin_n,
  input wire       riPin_n,
  input wire       dcdPin_n,
  input wire       dtrPin,
  input wire       bitTick,
  // Endpoint map
  input wire       highSpeed,
  input wire [9:0] bulkPacketBytes,
  input wire [3:0] bulkInEp,
  input wire [3:0] bulkOutEp,
  input wire [3:0] statusEp
);
  // Shadows of the mode and latch bits; a write counts from its own edge.
  reg  [1:0] mode_reg;
  reg        latch_reg;
  wire [3:0] pins = {dcdPin_n, riPin_n, dsrPin_n, ctsPin_n};
  wire       stRd = regRead && regAddr == 3'h6;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= 2'h0;
      latch_reg <= 1'h0;
    end else if (regWrite && regAddr == 3'h7) begin
      mode_reg <= regWrData[7:6];
    end else if (regWrite && regAddr == 3'h3) begin
      latch_reg <= regWrData[7];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Five quiet samples let a pin cross the two-flop synchroniser first.
  property p_msr; $stable(pins) [*5] ##0 stRd |=> regRdData[7:4] == ~$past(pins); endproperty
  a_msr: assert property (p_msr) else $error("status levels wrong");
  // Reads come three cycles apart, too soon for a later pin change to reach the flags.
  property p_clr; ($stable(pins) [*5] ##0 stRd) ##3 stRd |=> regRdData[3:0] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_lock; regRead && regAddr < 3'h2 && !latch_reg |=> regRdData == 8'h00; endproperty
  a_lock: assert property (p_lock) else $error("divisor not locked");
  property p_off; !mode_reg[1] [*3] |-> !dtrPin; endproperty
  a_off: assert property (p_off) else $error("direction active");
  property p_dir; (mode_reg[1] && $stable(mode_reg) && $stable(txBusy)) [*3]
    |-> dtrPin == (txBusy ~^ mode_reg[0]); endproperty
  a_dir: assert property (p_dir) else $error("direction level wrong");
  property p_tick; bitTick |=> !bitTick [*8]; endproperty
  a_tick: assert property (p_tick) else $error("bit rate too fast");
  property p_pkt; $stable(highSpeed) |=> bulkPacketBytes == ($past(highSpeed) ? 10'h200 : 10'h040);
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet size wrong");
  property p_ep; $past(reset_n) |-> {bulkInEp, bulkOutEp, statusEp}
    == {4'(2 * PORT_NUM - 1), 4'(2 * PORT_NUM), 4'h9}; endproperty
  a_ep: assert property (p_ep) else $error("endpoint numbers wrong");
endmodule // spmsb_port_sva
bind spmsb_serial_port spmsb_port_sva #(.PORT_NUM(PORT_NUM)) chk (.ref_clk, .reset_n, .regAddr,
  .regWrite, .regRead, .regWrData, .regRdData, .txBusy, .ctsPin_n, .dsrPin_n, .riPin_n,
  .dcdPin_n, .dtrPin, .bitTick, .highSpeed, .bulkPacketBytes, .bulkInEp, .bulkOutEp, .statusEp);

// >>> verif/spmsb_serial_port_test.sv
// Self-checking bench for the serial port block.
`timescale 1ns/1ps
module spmsb_serial_port_test;
  reg         ref_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [2:0]  regAddr = 3'h0;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg  [7:0]  regWrData = 8'h00;
  reg         txBusy = 1'b0;
  reg         highSpeed = 1'b0;
  reg         statusLong = 1'b0;
  reg  [3:0]  assertReq = 4'h0;
  wire [3:0]  pinsN;
  wire [7:0]  regRdData;
  wire        dtrPin;
  wire        bitTick;
  wire        rdValid;
  wire [3:0]  bulkInEp, bulkOutEp, statusEp, statusPacketBytes;
  wire [9:0]  bulkPacketBytes;
  reg  [7:0]  got, first;
  reg  [23:0] rows [0:3];
  integer     miscompares = 0;
  integer     checkCount = 0;
  integer     i, n;
  spmsb_serial_port #(.PORT_NUM(3)) dut (.ref_clk, .reset_n, .regAddr, .regWrite, .regRead,
    .regWrData, .regRdData, .regRdValid(rdValid), .txBusy, .ctsPin_n(pinsN[0]), .dsrPin_n(pinsN[1]),
    .riPin_n(pinsN[2]), .dcdPin_n(pinsN[3]), .dtrPin, .lineFormatLatch(), .sampleTick(),
    .bitTick, .highSpeed, .statusLong, .bulkInEp, .bulkOutEp, .bulkPacketBytes, .statusEp,
    .statusPacketBytes);
  spmsb_modem_model modem (.ref_clk, .assertReq, .pinsN);
  // Free-running 250 MHz clock.
  initial forever #2 ref_clk = ~ref_clk;
  task chk(input [15:0] e, input [15:0] g);
    begin
      checkCount = checkCount + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  // One register access; an idle edge follows so strobes never re-rise in one step.
  task xfer(input w, input [2:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrite = w;
      regRead = !w;
      @(posedge ref_clk);
      #1;
      regWrite = 1'b0;
      regRead = 1'b0;
      got = regRdData;
      chk({15'h0000, !w}, {15'h0000, rdValid});
    end
  endtask
  // Skips one bit period, since a divisor change may stretch it, then counts the next.
  task per(input [15:0] e);
    begin
      while (bitTick !== 1'b1) begin @(posedge ref_clk); #1; end
      repeat (2) begin
        n = 0;
        do begin @(posedge ref_clk); #1; n = n + 1; end while (bitTick !== 1'b1);
      end
      chk(e, n[15:0]);
    end
  endtask
  task printVerdict;
    begin
      if (miscompares == 0 && checkCount > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog well beyond the roughly 13k cycles the sequence needs.
  initial begin
    #400000;
    miscompares = miscompares + 1;
    printVerdict;
  end
  // Rows are {offset, write data, read-back}; offset 2 keeps nothing.
  initial begin
    rows[0] = 24'h005A5A;
    rows[1] = 24'h01A5A5;
    rows[2] = 24'h073C3C;
    rows[3] = 24'h027700;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    xfer(1, 3'h3, 8'h80);
    xfer(0, 3'h0, 8'h00);
    chk(8'h01, got);
    xfer(0, 3'h1, 8'h00);
    chk(8'h00, got);
    per(16'd16);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1, rows[i][18:16], rows[i][15:8]);
      xfer(0, rows[i][18:16], 8'h00);
      chk(rows[i][7:0], got);
    end
    xfer(1, 3'h3, 8'h00);
    xfer(1, 3'h0, 8'h33);
    xfer(0, 3'h0, 8'h00);
    chk(8'h00, got);
    xfer(1, 3'h3, 8'h80);
    xfer(0, 3'h0, 8'h00);
    chk(8'h5A, got);
    xfer(1, 3'h0, 8'h03);
    xfer(1, 3'h1, 8'h00);
    per(16'd48);
    xfer(1, 3'h0, 8'h02);
    xfer(1, 3'h1, 8'h01);
    per(16'd4128);
    // Assert then release each pin; ring flags only on its release.
    for (i = 0; i < 4; i = i + 1) begin
      assertReq[i] = 1'b1;
      repeat (6) @(posedge ref_clk);
      xfer(0, 3'h6, 8'h00);
      chk((8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i), got);
      assertReq[i] = 1'b0;
      repeat (6) @(posedge ref_clk);
      xfer(0, 3'h6, 8'h00);
      chk(8'h01 << i, got);
      xfer(0, 3'h6, 8'h00);
      chk(8'h00, got);
    end
    // A change near a read must show on exactly one of two reads.
    for (i = 0; i < 6; i = i + 1) begin
      assertReq[0] = ~assertReq[0];
      repeat (i) @(posedge ref_clk);
      xfer(0, 3'h6, 8'h00);
      first = got;
      repeat (6) @(posedge ref_clk);
      xfer(0, 3'h6, 8'h00);
      chk(16'h1, first[0] ^ got[0]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      xfer(1, 3'h7, {i < 4, i[1], 6'h3F});
      txBusy = i[0];
      repeat (4) @(posedge ref_clk);
      #1;
      chk(i < 4 && i[1] == i[0], dtrPin);
    end
    for (i = 0; i < 4; i = i + 1) begin
      highSpeed = i[0];
      statusLong = i[1];
      repeat (2) @(posedge ref_clk);
      #1;
      chk(i[0] ? 16'h200 : 16'h040, bulkPacketBytes);
      chk(i[1] ? 16'hD : 16'h5, statusPacketBytes);
      chk(16'h569, {bulkInEp, bulkOutEp, statusEp});
    end
    // Mid-run reset must restore divisor, scratch and an idle direction output.
    reset_n = 1'b0;
    @(posedge ref_clk);
    #1;
    chk(16'h0000, {15'h0000, dtrPin});
    reset_n = 1'b1;
    xfer(1, 3'h3, 8'h80);
    xfer(0, 3'h0, 8'h00);
    chk(8'h01, got);
    xfer(0, 3'h7, 8'h00);
    chk(8'h00, got);
    printVerdict;
  end
endmodule // spmsb_serial_port_test
